/* src/lcc_charge_ctrl.sv */
// Charge cycle sequencer for a single-cell lithium-ion linear charger.
`timescale 1ns/1ps
module lcc_charge_ctrl
  import lcc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              charger_enable_n,
  input  wire lcc_cmp_s          cmp_in,
  output logic                   charging,
  output logic                   trickle,
  output logic [CUR_W-1:0]       current_cmd,
  output logic                   temp_hold,
  output logic                   charge_status_n_o,
  output logic                   charge_status_n_oe
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  logic [10:0] sync1;
  logic [10:0] sync2;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync1 <= 11'h0ff;
      sync2 <= 11'h0ff;
    end else begin
      sync1 <= {charger_enable_n, cmp_in};
      sync2 <= sync1;
    end
  end

  logic     en_n;
  lcc_cmp_s cmp;
  assign en_n = sync2[10];
  assign cmp  = lcc_cmp_s'(sync2[9:0]);

  logic qualified;
  logic shutdown;
  logic ntc_bad;
  assign qualified = cmp.supply_lockout_ok && cmp.supply_above_bat;
  assign shutdown  = en_n || !qualified;
  assign ntc_bad   = !cmp.ntc_grounded && (cmp.ntc_hot || cmp.ntc_cold);

  // --------------------------------------------------------------------
  // Slow tick and blink phase
  // --------------------------------------------------------------------
  logic [16:0] tick_div;
  logic        tick;
  logic [6:0]  qtr_cnt;
  logic [1:0]  phase;

  always_ff @(posedge mclk) begin
    if (!rst_b || shutdown) begin
      tick_div <= '0;
      tick     <= 1'b0;
    end else if (tick_div == 17'(TICK_CYC - 1)) begin
      tick_div <= '0;
      tick     <= 1'b1;
    end else begin
      tick_div <= tick_div + 17'h1;
      tick     <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || shutdown) begin
      qtr_cnt <= '0;
      phase   <= '0;
    end else if (tick) begin
      if (qtr_cnt == 7'(BLINK_QTR_MS - 1)) begin
        qtr_cnt <= '0;
        phase   <= phase + 2'h1;
      end else begin
        qtr_cnt <= qtr_cnt + 7'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  lcc_state_e state;
  lcc_state_e next_state;
  logic       recharge;
  logic       start_cycle;
  logic       timer_zero;
  logic       defect_zero;
  logic       filt_zero;
  logic       soft_zero;
  logic       rechg_req;

  always_comb begin
    next_state  = state;
    start_cycle = 1'b0;
    unique case (state)
      LCC_OFF: begin
        if (!shutdown) begin
          next_state  = LCC_CHARGE;
          start_cycle = 1'b1;
        end
      end
      LCC_CHARGE: begin
        if (ntc_bad) begin
          next_state = LCC_HOLD;
        end else if (trickle && defect_zero) begin
          next_state = LCC_DEFECT;
        end else if (timer_zero) begin
          next_state = LCC_DONE;
        end else if (trickle && !cmp.bat_low) begin
          start_cycle = 1'b1;
        end
      end
      LCC_HOLD: begin
        if (!ntc_bad) begin
          next_state = LCC_CHARGE;
        end
      end
      LCC_DONE: begin
        if (rechg_req) begin
          next_state  = LCC_CHARGE;
          start_cycle = 1'b1;
        end
      end
      LCC_DEFECT: begin
        next_state = LCC_DEFECT;
      end
      default: begin
        next_state = LCC_OFF;
      end
    endcase
    if (shutdown) begin
      next_state  = LCC_OFF;
      start_cycle = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= LCC_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || shutdown) begin
      recharge <= 1'b0;
    end else if (state == LCC_DONE && rechg_req) begin
      recharge <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || shutdown) begin
      trickle <= 1'b0;
    end else if (start_cycle) begin
      trickle <= cmp.bat_low;
    end
  end

  // --------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------
  logic             timer_load;
  logic [TIMER_W-1:0] timer_val;
  logic             run_tick;
  assign timer_load = (state == LCC_OFF) ||
                      (state == LCC_DONE && rechg_req);
  assign timer_val  = (state == LCC_DONE) ? TIMER_W'(RECHG_TIME_MS) :
                                            TIMER_W'(FULL_TIME_MS);
  assign run_tick   = tick && state == LCC_CHARGE;

  lcc_counter #(.W(TIMER_W)) u_term_timer (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .load     (timer_load),
    .load_val (timer_val),
    .en       (run_tick),
    .zero     (timer_zero)
  );

  lcc_counter #(.W(TIMER_W)) u_defect_timer (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .load     (start_cycle || state == LCC_OFF),
    .load_val (TIMER_W'(DEFECT_TIME_MS)),
    .en       (run_tick && trickle),
    .zero     (defect_zero)
  );

  // The recharge comparator must stay asserted for the whole filter window.
  lcc_counter #(.W(FILT_W)) u_rechg_filter (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .load     (state != LCC_DONE || !cmp.bat_below_rechg),
    .load_val (FILT_W'(FILTER_CYC)),
    .en       (1'b1),
    .zero     (filt_zero)
  );
  assign rechg_req = filt_zero && cmp.bat_below_rechg;

  lcc_counter #(.W(SOFT_W)) u_soft_start (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .load     (start_cycle),
    .load_val (SOFT_W'(SOFT_START_CYC)),
    .en       (state == LCC_CHARGE),
    .zero     (soft_zero)
  );

  // --------------------------------------------------------------------
  // Current command with soft-start ramp
  // --------------------------------------------------------------------
  logic [CUR_W-1:0] target;
  logic [7:0]       ramp_div;
  assign target = trickle ? CUR_TRKL : CUR_FULL;

  always_ff @(posedge mclk) begin
    if (!rst_b || shutdown || start_cycle) begin
      ramp_div <= '0;
    end else if (ramp_div == 8'(SOFT_START_CYC / 256 - 1)) begin
      ramp_div <= '0;
    end else begin
      ramp_div <= ramp_div + 8'h1;
    end
  end

  // Decided on the next state so that no current is commanded in hold.
  always_ff @(posedge mclk) begin
    if (!rst_b || next_state != LCC_CHARGE || start_cycle) begin
      current_cmd <= '0;
    end else if (soft_zero || current_cmd >= target) begin
      current_cmd <= target;
    end else if (ramp_div == '0) begin
      current_cmd <= current_cmd + CUR_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      charging  <= 1'b0;
      temp_hold <= 1'b0;
    end else begin
      charging  <= (next_state == LCC_CHARGE);
      temp_hold <= (next_state == LCC_HOLD);
    end
  end

  // --------------------------------------------------------------------
  // Status pin
  // --------------------------------------------------------------------
  lcc_stat_e stat;
  always_comb begin
    stat = LCC_ST_OPEN;
    unique case (state)
      LCC_CHARGE: begin
        if (!cmp.below_c10 || (cmp.droop_limit && !cmp.cv_mode)) begin
          stat = LCC_ST_LOW;
        end else begin
          stat = LCC_ST_OPEN;
        end
      end
      LCC_HOLD:   stat = LCC_ST_P25;
      LCC_DEFECT: stat = LCC_ST_P75;
      LCC_DONE:   stat = LCC_ST_OPEN;
      LCC_OFF:    stat = LCC_ST_OPEN;
      default:    stat = LCC_ST_OPEN;
    endcase
  end

  // Open-drain: output level is always low, only the enable moves.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      charge_status_n_o  <= 1'b0;
      charge_status_n_oe <= 1'b0;
    end else begin
      charge_status_n_o <= 1'b0;
      unique case (stat)
        LCC_ST_LOW:  charge_status_n_oe <= 1'b1;
        LCC_ST_P75:  charge_status_n_oe <= (phase != 2'h3);
        LCC_ST_P25:  charge_status_n_oe <= (phase == 2'h0);
        LCC_ST_OPEN: charge_status_n_oe <= 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  AST_SHUTDOWN_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
    shutdown |=> state == LCC_OFF)
    else $error("shutdown did not force the off state");
  AST_UNQUALIFIED: assert property (@(posedge mclk) disable iff (!rst_b)
    !qualified |=> !charging)
    else $error("charging without qualified supply");
  AST_TRICKLE_CUR: assert property (@(posedge mclk) disable iff (!rst_b)
    trickle && state == LCC_CHARGE |=> current_cmd <= CUR_TRKL)
    else $error("trickle current above one tenth");
  AST_DEFECT_BLINK: assert property (@(posedge mclk) disable iff (!rst_b)
    state == LCC_DEFECT && phase == 2'h3 && $stable(phase)
      |=> !charge_status_n_oe)
    else $error("defect blink pattern wrong");
  AST_TRICKLE_EXIT: assert property (@(posedge mclk) disable iff (!rst_b)
    state == LCC_CHARGE && trickle && !cmp.bat_low && !ntc_bad
      && !defect_zero && !timer_zero && !shutdown |=> !trickle)
    else $error("trickle did not restart");
  AST_LOW_IN_CYCLE: assert property (@(posedge mclk) disable iff (!rst_b)
    state == LCC_CHARGE && !cmp.below_c10 |=> charge_status_n_oe)
    else $error("status not low while charging");
  AST_OPEN_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
    state == LCC_OFF |=> !charge_status_n_oe)
    else $error("status driven while disabled");
  AST_TIMER_END: assert property (@(posedge mclk) disable iff (!rst_b)
    state == LCC_CHARGE && timer_zero && !trickle && !ntc_bad && !shutdown
      |=> state == LCC_DONE ##1 !charge_status_n_oe)
    else $error("timer expiry did not end the cycle");
  AST_DROOP_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
    state == LCC_CHARGE && cmp.droop_limit && !cmp.cv_mode
      |=> charge_status_n_oe)
    else $error("droop limiting released status");
  AST_RAMP_START: assert property (@(posedge mclk) disable iff (!rst_b)
    start_cycle |=> current_cmd == '0)
    else $error("ramp did not start at zero");
  AST_HOLD_FREEZE: assert property (@(posedge mclk) disable iff (!rst_b)
    state == LCC_HOLD |-> !run_tick && current_cmd == '0)
    else $error("hold did not freeze the cycle");
  AST_NTC_GND: assert property (@(posedge mclk) disable iff (!rst_b)
    cmp.ntc_grounded && state == LCC_CHARGE && !shutdown
      |=> state != LCC_HOLD)
    else $error("hold entered with thermistor grounded");

  COV_DONE:   cover property (@(posedge mclk) state == LCC_DONE);
  COV_DEFECT: cover property (@(posedge mclk) state == LCC_DEFECT);
  COV_HOLD:   cover property (@(posedge mclk) state == LCC_HOLD);
  COV_RECHG:  cover property (@(posedge mclk) recharge && charging);

endmodule : lcc_charge_ctrl

/* src/lcc_pkg.sv */
// Package for the charge cycle sequencer: constants, states and carriers.
package lcc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned SOFT_START_US  = 180;
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  localparam int unsigned FILTER_MS      = 2;
  localparam int unsigned FILTER_CYC     = FILTER_MS * 1000 * CLK_MHZ;
  // Slow oscillator tick period in cycles (1 ms at 125 MHz).
  localparam int unsigned TICK_CYC       = 125000;
  localparam int unsigned TICKS_PER_MS   = 1;
  // 2 Hz blink: 500 ms period, split in quarters of 125 ms.
  localparam int unsigned BLINK_QTR_MS   = 125;
  // Hour-scale timers in ms ticks.
  localparam int unsigned FULL_TIME_MS   = 16200000; // 4.5 hours
  localparam int unsigned RECHG_TIME_MS  = 8100000;  // 2.25 hours
  localparam int unsigned DEFECT_TIME_MS = 4050000;  // 1.125 hours
  localparam int unsigned SOFT_W         = 15;
  localparam int unsigned TIMER_W        = 24;
  localparam int unsigned FILT_W         = 18;

  // ----------------------------------------------------------------------
  // Current command
  // ----------------------------------------------------------------------
  localparam int unsigned   CUR_W     = 8;
  localparam logic [7:0]    CUR_FULL  = 8'hff;
  localparam logic [7:0]    CUR_TRKL  = 8'h1a; // one tenth of full scale

  // ----------------------------------------------------------------------
  // States and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    LCC_OFF     = 3'b000,
    LCC_CHARGE  = 3'b001,
    LCC_HOLD    = 3'b101,
    LCC_DONE    = 3'b011,
    LCC_DEFECT  = 3'b110
  } lcc_state_e;

  typedef enum logic [1:0] {
    LCC_ST_OPEN  = 2'b00,
    LCC_ST_LOW   = 2'b01,
    LCC_ST_P75   = 2'b11,
    LCC_ST_P25   = 2'b10
  } lcc_stat_e;

  typedef struct packed {
    logic supply_lockout_ok; // supply above lockout
    logic supply_above_bat;  // supply 82 mV above battery
    logic bat_low;           // battery below 2.9 V
    logic bat_below_rechg;   // battery below 4.1 V
    logic ntc_hot;
    logic ntc_cold;
    logic ntc_grounded;
    logic below_c10;         // current under one tenth
    logic cv_mode;           // constant-voltage loop active
    logic droop_limit;       // input_droop_current_limit active
  } lcc_cmp_s;

endpackage : lcc_pkg

/* src/lcc_counter.sv */
// Loadable down counter with enable, used for every timer of the sequencer.
`timescale 1ns/1ps
module lcc_counter
  import lcc_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         en,
  output logic              zero
);
  logic [W-1:0] cnt;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (en && cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  assign zero = (cnt == '0);
endmodule : lcc_counter

/* testbench/lcc_partner.sv */
// Far-side model: supply, battery and thermistor comparators, status pull-up.
`timescale 1ns/1ps
module lcc_partner
  import lcc_pkg::*;
(
  input  wire lcc_cmp_s knob,
  output lcc_cmp_s      cmp_out,
  input  wire logic     status_n_o,
  input  wire logic     status_n_oe,
  output logic          status_pin
);
  // ----------------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------------
  // A grounded thermistor input sits far below the hot trip point, so the
  // hot comparator really trips; the block has to ignore it.
  always_comb begin
    cmp_out = knob;
    if (!knob.supply_lockout_ok) begin
      cmp_out.supply_above_bat = 1'b0;
    end
    if (knob.ntc_grounded) begin
      cmp_out.ntc_hot  = 1'b1;
      cmp_out.ntc_cold = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status pin
  // ----------------------------------------------------------------------
  // Open drain with an external pull-up, as an LED or host input sees it.
  assign status_pin = status_n_oe ? status_n_o : 1'b1;
endmodule : lcc_partner

/* testbench/tb_lcc_charge_ctrl.sv */
// Self-checking testbench for the charge cycle sequencer.
`timescale 1ns/1ps
module tb_lcc_charge_ctrl;
  import lcc_pkg::*;
  logic             mclk = 1'b0;
  logic             rst_b;
  logic             charger_enable_n;
  lcc_cmp_s         knob;
  lcc_cmp_s         cmp_in;
  logic             charging;
  logic             trickle;
  logic             temp_hold;
  logic             stat_o;
  logic             stat_oe;
  logic             status_pin;
  logic [CUR_W-1:0] current_cmd;
  int               n_fail = 0;
  int               compares = 0;
  int               cycles = 0;

  always #4 mclk = ~mclk;

  lcc_charge_ctrl dut_u (
    .mclk(mclk), .rst_b(rst_b), .charger_enable_n(charger_enable_n),
    .cmp_in(cmp_in), .charging(charging), .trickle(trickle),
    .current_cmd(current_cmd), .temp_hold(temp_hold),
    .charge_status_n_o(stat_o), .charge_status_n_oe(stat_oe));

  lcc_partner partner_u (
    .knob(knob), .cmp_out(cmp_in), .status_n_o(stat_o),
    .status_n_oe(stat_oe), .status_pin(status_pin));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Two synchroniser stages plus state and output registers fit well
  // inside eight cycles.
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask : settle

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_qualify();
    knob.supply_lockout_ok = 1'b1;
    settle();
    chk({7'h00, charging}, 8'h00, "charging before qualify");
    chk({7'h00, status_pin}, 8'h01, "status open when off");
    knob.supply_above_bat = 1'b1;
    settle();
    chk({7'h00, charging}, 8'h01, "charging after qualify");
    chk({7'h00, status_pin}, 8'h00, "status low in cycle");
    chk({7'h00, trickle}, 8'h00, "no trickle, battery ok");
    repeat (11000) @(posedge mclk);
    #1;
    chk({7'h00, current_cmd > 8'h00 && current_cmd < CUR_FULL}, 8'h01,
        "ramp midway");
    repeat (12000) @(posedge mclk);
    #1;
    chk(current_cmd, CUR_FULL, "ramp reaches full");
  endtask : t_qualify

  task automatic t_status();
    knob.below_c10 = 1'b1;
    knob.cv_mode = 1'b1;
    settle();
    chk({7'h00, status_pin}, 8'h01, "status open under tenth");
    knob.cv_mode = 1'b0;
    knob.droop_limit = 1'b1;
    settle();
    chk({7'h00, status_pin}, 8'h00, "droop keeps status low");
    knob.below_c10 = 1'b0;
    knob.droop_limit = 1'b0;
    settle();
    chk({7'h00, status_pin}, 8'h00, "status low again");
  endtask : t_status

  task automatic t_hold();
    knob.ntc_hot = 1'b1;
    settle();
    chk({7'h00, temp_hold}, 8'h01, "hot enters hold");
    chk({7'h00, charging}, 8'h00, "hold suspends");
    chk(current_cmd, 8'h00, "hold stops current");
    chk({7'h00, status_pin}, 8'h00, "hold blink on quarter");
    knob.ntc_hot = 1'b0;
    settle();
    chk({7'h00, charging}, 8'h01, "resume after hot");
    knob.ntc_cold = 1'b1;
    settle();
    chk({7'h00, temp_hold}, 8'h01, "cold enters hold");
    knob.ntc_cold = 1'b0;
    settle();
    chk({7'h00, temp_hold}, 8'h00, "cold hold released");
    knob.ntc_grounded = 1'b1;
    settle();
    chk({7'h00, temp_hold}, 8'h00, "grounded ignores trip");
    chk({7'h00, charging}, 8'h01, "grounded keeps charging");
    knob.ntc_grounded = 1'b0;
    settle();
  endtask : t_hold

  task automatic t_shutdown();
    charger_enable_n = 1'b1;
    settle();
    chk({7'h00, charging}, 8'h00, "enable high stops");
    chk({7'h00, status_pin}, 8'h01, "status open disabled");
    charger_enable_n = 1'b0;
    settle();
    chk({7'h00, charging}, 8'h01, "restart on enable");
    knob.supply_lockout_ok = 1'b0;
    settle();
    chk({7'h00, charging}, 8'h00, "supply gone stops");
    knob.supply_lockout_ok = 1'b1;
    settle();
    chk({7'h00, charging}, 8'h01, "restart on supply");
  endtask : t_shutdown

  task automatic t_trickle();
    charger_enable_n = 1'b1;
    settle();
    knob.bat_low = 1'b1;
    charger_enable_n = 1'b0;
    settle();
    chk({7'h00, trickle}, 8'h01, "trickle on low battery");
    repeat (23000) @(posedge mclk);
    #1;
    chk(current_cmd, CUR_TRKL, "trickle current");
    knob.bat_low = 1'b0;
    settle();
    chk({7'h00, trickle}, 8'h00, "trickle left on rise");
    chk({7'h00, charging}, 8'h01, "cycle restarted");
    chk({7'h00, current_cmd < CUR_TRKL}, 8'h01,
        "ramp starts again");
  endtask : t_trickle

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    charger_enable_n = 1'b0;
    knob = '0;
    repeat (3) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_qualify();
    t_status();
    t_hold();
    t_shutdown();
    t_trickle();
    tally_and_finish();
  end
endmodule : tb_lcc_charge_ctrl
